// File: rtl/drc_regs.svh
`ifndef DRC_REGS_SVH
`define DRC_REGS_SVH

`define ENA1_OFF        12'he80
`define CFG1_OFF        12'he84
`define ENA2_OFF        12'he88
`define CFG2_OFF        12'he8c
`define KNEE1_OFF       12'he90
`define GAIN1_OFF       12'he94
`define KNEE2_OFF       12'he98
`define GAIN2_OFF       12'he9c
`define STS_OFF         12'hea0

`define ENA_L_BIT       1
`define ENA_R_BIT       0

`define GATE_EN_BIT     0
`define KNEE2_EN_BIT    1
`define CLIP_EN_BIT     2
`define FR_EN_BIT       3
`define DET_EN_BIT      4
`define DET_TYPE_BIT    5
`define SEQ_TRIG_BIT    6
`define HI_SLOPE_F      9:7
`define LO_SLOPE_F      12:10
`define GATE_EXP_F      14:13
`define ATK_F           18:15
`define DCY_F           22:19
`define FR_DCY_F        26:23
`define FR_THR_F        30:27

`define K1_IN_F         5:0
`define K1_OUT_F        10:6
`define K2_IN_F         15:11
`define K2_OUT_F        20:16

`define MIN_GAIN_F      3:0
`define MAX_GAIN_F      7:4
`define GATE_MIN_F      11:8
`define DET_PK_F        16:12
`define DET_RMS_F       21:17

`define ENA_RESET       2'h0
`define CFG_RESET       32'h0131_1200
`define KNEE_RESET      32'h0000_0000
`define GAIN_RESET      32'h0000_0844

`define K1_IN_MAX       6'h3c
`define K1_OUT_MAX      5'h1e
`define K2_IN_BASE      12'sh030
`define K2_OUT_BASE     12'sh028
`define SLOPE_SHIFT     2
`define MIN_GAIN_SHIFT  3
`define MAX_GAIN_SHIFT  2
`define LVL_SHIFT       3
`define LVL_SILENT      12'sh080
`define AVG_SHIFT       3
`define GAIN_FRAC       6
`define STEP_ONE        18'h00040
`define RISE_UNITS      12'sh010
`define CHAN_CYCLES     8
`define FX_CLEAR_US     125
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// File: rtl/drc_pkg.sv
package drc_pkg;
  typedef logic signed [11:0] db_t;
  typedef enum logic {
    DET_PEAK = 1'b0,
    DET_RMS  = 1'b1
  } det_mode_t;
endpackage : drc_pkg

// File: rtl/drc_gain_calc.sv
`timescale 1ns/1ps
`include "drc_regs.svh"
module drc_gain_calc (
  input  wire logic [31:0] cfg_word,
  input  wire logic [31:0] knee_word,
  input  wire logic [31:0] gain_word,
  input  wire drc_pkg::db_t level,
  output drc_pkg::db_t     target
);
  import drc_pkg::*;
  wire [5:0]         k1i_code = knee_word[`K1_IN_F];
  wire [4:0]         k1o_code = knee_word[`K1_OUT_F];
  wire db_t          k1_in    = db_t'((k1i_code > `K1_IN_MAX) ? `K1_IN_MAX : k1i_code);
  wire db_t          k1_out   = db_t'((k1o_code > `K1_OUT_MAX) ? `K1_OUT_MAX : k1o_code);
  wire db_t          k2_in    = `K2_IN_BASE + db_t'({knee_word[`K2_IN_F], 1'b0});
  wire db_t          k2_out   = `K2_OUT_BASE + db_t'({knee_word[`K2_OUT_F], 1'b0});
  wire signed [15:0] hi       = 16'($signed({1'b0, cfg_word[`HI_SLOPE_F]}));
  wire signed [15:0] lo       = 16'($signed({1'b0, cfg_word[`LO_SLOPE_F]}));
  wire signed [15:0] ex       = 16'($signed({1'b0, cfg_word[`GATE_EXP_F]})) + 16'sh1;
  // Compression slopes are in quarters, so code 4 is unity and 0 pins the output
  wire signed [15:0] t_hi     = 16'(k1_in - level) * hi;
  wire signed [15:0] t_lo     = 16'(level - k1_in) * lo;
  wire signed [15:0] t_k2     = 16'(k2_in - k1_in) * lo;
  wire signed [15:0] t_gt     = 16'(level - k2_in) * ex;
  wire db_t          o_hi     = k1_out - db_t'(t_hi >>> `SLOPE_SHIFT);
  wire db_t          o_lo     = k1_out + db_t'(t_lo >>> `SLOPE_SHIFT);
  wire db_t          o_k2     = k1_out + db_t'(t_k2 >>> `SLOPE_SHIFT);
  wire db_t          g_start  = cfg_word[`KNEE2_EN_BIT] ? k2_out : o_k2;
  wire db_t          o_gate   = g_start + db_t'(t_gt);
  wire               in_gate  = cfg_word[`GATE_EN_BIT] && (level > k2_in) && (level > k1_in);
  wire db_t          out_lvl  = (level <= k1_in) ? o_hi : (in_gate ? o_gate : o_lo);
  wire db_t          raw      = level - out_lvl;
  wire db_t          floor_g  = -(db_t'(in_gate ? gain_word[`GATE_MIN_F] : gain_word[`MIN_GAIN_F]) <<< `MIN_GAIN_SHIFT);
  wire db_t          ceil_g   = db_t'(gain_word[`MAX_GAIN_F]) <<< `MAX_GAIN_SHIFT;
  wire db_t          lim_lo   = (raw < floor_g) ? floor_g : raw;
  assign target = (lim_lo > ceil_g) ? ceil_g : lim_lo;
endmodule : drc_gain_calc

// File: rtl/drc_gain_apply.sv
`timescale 1ns/1ps
module drc_gain_apply (
  input  wire logic signed [15:0] sample,
  input  wire drc_pkg::db_t       gain,
  output logic signed [15:0]      result
);
  import drc_pkg::*;
  // Eight steps of 0.75 dB per 6 dB octave, Q1.14
  localparam logic [15:0] MANT [8] = '{16'h4000, 16'h45cb, 16'h4c1c, 16'h52ff,
                                       16'h5a82, 16'h62b3, 16'h6ba2, 16'h7560};
  wire db_t          octs = gain >>> 3;
  wire signed [15:0] mant = $signed(MANT[gain[2:0]]);
  wire signed [47:0] prod = 48'(sample) * 48'(mant);
  wire signed [47:0] up   = prod <<< ((octs > 12'sd15) ? 4'd15 : octs[3:0]);
  wire signed [47:0] dn   = (octs < -12'sd31) ? 48'sh0 : (prod >>> 6'(-octs));
  wire signed [47:0] scl  = ((octs >= 12'sd0) ? up : dn) >>> 14;
  // Saturate rather than wrap so a loud boost clips instead of inverting
  assign result = (scl > 48'sh7fff) ? 16'sh7fff : ((scl < -48'sh8000) ? -16'sh8000 : scl[15:0]);
endmodule : drc_gain_apply

// File: rtl/dynamic_range_control.sv
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "drc_regs.svh"
// How it works
// - Per pair, bit 1 enables left and bit 0 enables right.
// - High slope above the first knee, low slope below it.
// - Gate enable selects an expansion region; otherwise low slope continues.
// - Second knee enable drops output steeply into the gate region.
// - Compression slope: 1 unity gain, below 1 compresses, 0 holds output.
// - Gate slope: 1 unity gain, above 1 expands.
// - Knee point set by input and output levels; 0 dB output follows.
// - Gain never below compression floor, or gate floor inside the gate.
// - Gain never above the maximum gain limit.
// - Gain follows the averaged level, not single samples.
// - Attack sets fall rate of gain; decay sets rise rate.
// - Clip avoidance looks ahead one sample and speeds attack.
// - Fast release decay replaces decay when crest factor exceeds threshold.
// - Activity detect needs its enable and the channel; type selects threshold.
// - Each pair's activity detect goes out to the interrupt logic.
// - Only pair 1 activity, when enabled, triggers the write sequencer.
// - An underclocked enable fails; running paths stay; status shows result.
// - Knee input codes step 0.75 dB to -45 dB; higher codes reserved.
module dynamic_range_control #(
  parameter int CHAN_CYCLES = `CHAN_CYCLES
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        sample_valid,
  input  wire logic [63:0] sample_in,
  output logic             out_valid,
  output logic [63:0]      sample_out,
  output logic [1:0]       activity_detect,
  output logic             sequencer_trigger
);
  import drc_pkg::*;

  localparam int NCH = 4;

  logic [1:0]         ena_reg [2];
  logic [31:0]        cfg_reg [2];
  logic [31:0]        knee_reg [2];
  logic [31:0]        gain_reg [2];
  logic               awready_reg;
  logic               wready_reg;
  logic               bvalid_reg;
  logic [1:0]         bresp_reg;
  logic               arready_reg;
  logic               rvalid_reg;
  logic [31:0]        rdata_reg;
  logic [1:0]         rresp_reg;
  logic               aw_got_reg;
  logic               w_got_reg;
  logic [11:0]        wr_addr_reg;
  logic [31:0]        wr_data_reg;
  logic [3:0]         wr_strb_reg;
  logic [15:0]        cyc_cnt_reg;
  logic [15:0]        period_reg;
  logic [3:0]         granted_reg;
  logic [3:0]         grant_next;
  logic [2:0]         used;
  logic               out_valid_reg;
  logic [15:0]        out_reg [NCH];
  db_t                avg_reg [NCH];
  logic signed [17:0] acc_reg [NCH];
  logic signed [15:0] hold_reg [NCH];
  logic [1:0]         activity_reg;
  logic               seq_reg;
  wire  [3:0]         det_w;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        m[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return m;
  endfunction : merge

  function automatic db_t level_of(input logic signed [15:0] s);
    logic [15:0] mag;
    logic [3:0]  msb;
    mag = s[15] ? 16'(-s) : s;
    msb = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (mag[i]) begin
        msb = 4'(i);
      end
    end
    return (mag == 16'h0) ? `LVL_SILENT : db_t'({4'hf - msb, 3'h0});
  endfunction : level_of

  // Write channel: address and data taken in either order
  wire aw_fire   = s_axi_awvalid & awready_reg;
  wire w_fire    = s_axi_wvalid & wready_reg;
  wire do_write  = aw_got_reg & w_got_reg & ~bvalid_reg;
  wire [31:0] wr_merged_cfg0  = merge(cfg_reg[0], wr_data_reg, wr_strb_reg);
  wire [31:0] wr_merged_cfg1  = merge(cfg_reg[1], wr_data_reg, wr_strb_reg);
  wire [31:0] wr_merged_knee0 = merge(knee_reg[0], wr_data_reg, wr_strb_reg);
  wire [31:0] wr_merged_knee1 = merge(knee_reg[1], wr_data_reg, wr_strb_reg);
  wire [31:0] wr_merged_gain0 = merge(gain_reg[0], wr_data_reg, wr_strb_reg);
  wire [31:0] wr_merged_gain1 = merge(gain_reg[1], wr_data_reg, wr_strb_reg);
  wire hit_ena1  = wr_addr_reg == `ENA1_OFF;
  wire hit_ena2  = wr_addr_reg == `ENA2_OFF;
  wire hit_cfg1  = wr_addr_reg == `CFG1_OFF;
  wire hit_cfg2  = wr_addr_reg == `CFG2_OFF;
  wire hit_knee1 = wr_addr_reg == `KNEE1_OFF;
  wire hit_knee2 = wr_addr_reg == `KNEE2_OFF;
  wire hit_gain1 = wr_addr_reg == `GAIN1_OFF;
  wire hit_gain2 = wr_addr_reg == `GAIN2_OFF;
  wire wr_hit    = hit_ena1 | hit_ena2 | hit_cfg1 | hit_cfg2 | hit_knee1 | hit_knee2 | hit_gain1 | hit_gain2;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      aw_got_reg  <= 1'b0;
      w_got_reg   <= 1'b0;
      wr_addr_reg <= 12'h000;
      wr_data_reg <= 32'h0000_0000;
      wr_strb_reg <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `RESP_OKAY;
    end else begin
      awready_reg <= s_axi_awvalid & ~awready_reg & ~aw_got_reg;
      wready_reg  <= s_axi_wvalid & ~wready_reg & ~w_got_reg;
      if (aw_fire) begin
        aw_got_reg  <= 1'b1;
        wr_addr_reg <= s_axi_awaddr;
      end
      if (w_fire) begin
        w_got_reg   <= 1'b1;
        wr_data_reg <= s_axi_wdata;
        wr_strb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_got_reg <= 1'b0;
        w_got_reg  <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Register storage; unmapped writes change nothing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int p = 0; p < 2; p++) begin
        ena_reg[p]  <= `ENA_RESET;
        cfg_reg[p]  <= `CFG_RESET;
        knee_reg[p] <= `KNEE_RESET;
        gain_reg[p] <= `GAIN_RESET;
      end
    end else if (do_write) begin
      if (hit_ena1 && wr_strb_reg[0]) ena_reg[0] <= wr_data_reg[1:0];
      if (hit_ena2 && wr_strb_reg[0]) ena_reg[1] <= wr_data_reg[1:0];
      if (hit_cfg1) cfg_reg[0] <= wr_merged_cfg0;
      if (hit_cfg2) cfg_reg[1] <= wr_merged_cfg1;
      if (hit_knee1) knee_reg[0] <= wr_merged_knee0;
      if (hit_knee2) knee_reg[1] <= wr_merged_knee1;
      if (hit_gain1) gain_reg[0] <= wr_merged_gain0;
      if (hit_gain2) gain_reg[1] <= wr_merged_gain1;
    end
  end

  // Read channel
  wire [11:0] ra     = s_axi_araddr;
  wire        ar_fire = s_axi_arvalid & arready_reg;
  wire [31:0] sts_word = {26'h0, activity_reg, granted_reg};
  wire [31:0] rd_mux =
    (ra == `ENA1_OFF)  ? {30'h0, ena_reg[0]} :
    (ra == `ENA2_OFF)  ? {30'h0, ena_reg[1]} :
    (ra == `CFG1_OFF)  ? cfg_reg[0] :
    (ra == `CFG2_OFF)  ? cfg_reg[1] :
    (ra == `KNEE1_OFF) ? knee_reg[0] :
    (ra == `KNEE2_OFF) ? knee_reg[1] :
    (ra == `GAIN1_OFF) ? gain_reg[0] :
    (ra == `GAIN2_OFF) ? gain_reg[1] :
    (ra == `STS_OFF)   ? sts_word : 32'h0000_0000;
  wire rd_hit = (ra == `ENA1_OFF) | (ra == `ENA2_OFF) | (ra == `CFG1_OFF) | (ra == `CFG2_OFF) |
                (ra == `KNEE1_OFF) | (ra == `KNEE2_OFF) | (ra == `GAIN1_OFF) | (ra == `GAIN2_OFF) |
                (ra == `STS_OFF);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= `RESP_OKAY;
    end else begin
      arready_reg <= s_axi_arvalid & ~arready_reg & ~rvalid_reg;
      if (ar_fire) begin
        rvalid_reg <= 1'b1;
        rdata_reg  <= rd_mux;
        rresp_reg  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rvalid_reg && s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // Cycle budget: measured clocks per sample against a fixed cost per channel
  wire [3:0] req = {ena_reg[1][`ENA_R_BIT], ena_reg[1][`ENA_L_BIT],
                    ena_reg[0][`ENA_R_BIT], ena_reg[0][`ENA_L_BIT]};

  always_comb begin
    grant_next = req & granted_reg;
    used       = 3'h0;
    for (int i = 0; i < NCH; i++) begin
      used = used + 3'(grant_next[i]);
    end
    // Running paths are kept even if the budget has shrunk since
    for (int i = 0; i < NCH; i++) begin
      if (req[i] && !grant_next[i] && ((int'(used) + 1) * CHAN_CYCLES <= int'(period_reg))) begin
        grant_next[i] = 1'b1;
        used          = used + 3'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cyc_cnt_reg <= 16'h0000;
      period_reg  <= 16'h0000;
      granted_reg <= 4'h0;
    end else begin
      granted_reg <= grant_next;
      if (sample_valid) begin
        cyc_cnt_reg <= 16'h0000;
        period_reg  <= cyc_cnt_reg + 16'h0001;
      end else if (cyc_cnt_reg != 16'hffff) begin
        cyc_cnt_reg <= cyc_cnt_reg + 16'h0001;
      end
    end
  end

  // One sample strobe serves every channel at the common effects rate
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    localparam int P = c / 2;
    wire [31:0]         cfg     = cfg_reg[P];
    wire signed [15:0]  x       = sample_in[16*c +: 16];
    wire db_t           inst    = level_of(x);
    wire db_t           crest   = avg_reg[c] - inst;
    wire db_t           avg_nx  = avg_reg[c] + ((inst - avg_reg[c]) >>> `AVG_SHIFT);
    wire db_t           target;
    wire db_t           cur     = db_t'(acc_reg[c] >>> `GAIN_FRAC);
    wire                fast_up = cfg[`CLIP_EN_BIT] && (crest > `RISE_UNITS);
    wire [17:0]         atk0    = `STEP_ONE >> cfg[`ATK_F];
    wire [17:0]         atk     = fast_up ? (atk0 << 1) : atk0;
    wire db_t           qr_thr  = {6'h00, cfg[`FR_THR_F], 2'b00};
    wire                quick   = cfg[`FR_EN_BIT] && (crest > qr_thr);
    wire [17:0]         dcy     = `STEP_ONE >> (quick ? cfg[`FR_DCY_F] : cfg[`DCY_F]);
    wire signed [17:0]  tgt_acc = {target, 6'h00};
    wire signed [17:0]  acc_dn  = acc_reg[c] - $signed(atk);
    wire signed [17:0]  acc_up  = acc_reg[c] + $signed(dcy);
    wire signed [17:0]  acc_nx  = (target < cur) ? ((acc_dn < tgt_acc) ? tgt_acc : acc_dn) :
                                  (target > cur) ? ((acc_up > tgt_acc) ? tgt_acc : acc_up) : acc_reg[c];
    // Look-ahead costs one sample of latency on this path
    wire signed [15:0]  src     = cfg[`CLIP_EN_BIT] ? hold_reg[c] : x;
    wire signed [15:0]  y;
    wire db_t           pk_thr  = {5'h00, gain_reg[P][`DET_PK_F], 2'b00};
    wire db_t           rms_thr = {5'h00, gain_reg[P][`DET_RMS_F], 2'b00};

    drc_gain_calc u_calc (
      .cfg_word  (cfg),
      .knee_word (knee_reg[P]),
      .gain_word (gain_reg[P]),
      .level     (avg_reg[c]),
      .target    (target)
    );

    drc_gain_apply u_apply (
      .sample (src),
      .gain   (cur),
      .result (y)
    );

    assign det_w[c] = granted_reg[c] && cfg[`DET_EN_BIT] &&
                      ((det_mode_t'(cfg[`DET_TYPE_BIT]) == DET_PEAK) ? (crest > pk_thr)
                                                                     : (avg_reg[c] < rms_thr));

    always_ff @(posedge aclk) begin
      if (!aresetn || !granted_reg[c]) begin
        avg_reg[c]  <= `LVL_SILENT;
        acc_reg[c]  <= 18'sh0;
        hold_reg[c] <= 16'sh0;
      end else if (sample_valid) begin
        avg_reg[c]  <= avg_nx;
        acc_reg[c]  <= acc_nx;
        hold_reg[c] <= x;
      end
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        out_reg[c] <= 16'h0000;
      end else if (sample_valid) begin
        out_reg[c] <= granted_reg[c] ? y : 16'h0000;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_valid_reg <= 1'b0;
      activity_reg  <= 2'h0;
      seq_reg       <= 1'b0;
    end else begin
      out_valid_reg <= sample_valid;
      activity_reg  <= {det_w[3] | det_w[2], det_w[1] | det_w[0]};
      seq_reg       <= (det_w[1] | det_w[0]) & cfg_reg[0][`SEQ_TRIG_BIT];
    end
  end

  assign s_axi_awready     = awready_reg;
  assign s_axi_wready      = wready_reg;
  assign s_axi_bvalid      = bvalid_reg;
  assign s_axi_bresp       = bresp_reg;
  assign s_axi_arready     = arready_reg;
  assign s_axi_rvalid      = rvalid_reg;
  assign s_axi_rdata       = rdata_reg;
  assign s_axi_rresp       = rresp_reg;
  assign out_valid         = out_valid_reg;
  assign sample_out        = {out_reg[3], out_reg[2], out_reg[1], out_reg[0]};
  assign activity_detect   = activity_reg;
  assign sequencer_trigger = seq_reg;

endmodule : dynamic_range_control

// File: testbench/drc_properties.sv
`timescale 1ns/1ps
module drc_properties #(
  parameter int CHAN_CYCLES = 8
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        sample_valid,
  input wire logic        out_valid,
  input wire logic [63:0] sample_out,
  input wire logic [1:0]  activity_detect,
  input wire logic        sequencer_trigger
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_offered;
    s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  endsequence
  sequence wr_answered;
    ##[1:6] s_axi_bvalid;
  endsequence
  a_write_answer: assert property (wr_offered |-> wr_answered)
    else $error("write response missing");
  a_read_answer: assert property (s_axi_arvalid && !s_axi_rvalid |-> ##[1:4] s_axi_rvalid)
    else $error("read response missing");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_awready_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("address ready held");
  a_out_after_in: assert property (sample_valid |=> out_valid)
    else $error("output pulse missing");
  a_out_has_cause: assert property (out_valid |-> $past(sample_valid))
    else $error("output pulse without sample");
  a_out_only_valid: assert property ($changed(sample_out) |-> out_valid)
    else $error("output changed between samples");
  // Trigger is registered in the same stage as the detect flag
  a_trigger_cause: assert property (sequencer_trigger |-> activity_detect[0] || $past(activity_detect[0]))
    else $error("trigger without pair one detect");
endmodule : drc_properties

bind dynamic_range_control drc_properties #(.CHAN_CYCLES(CHAN_CYCLES)) u_props (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .sample_valid(sample_valid),
  .out_valid(out_valid), .sample_out(sample_out), .activity_detect(activity_detect),
  .sequencer_trigger(sequencer_trigger));

// File: testbench/sample_source.sv
`timescale 1ns/1ps
module sample_source (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  period,
  input wire logic [15:0] amp,
  output logic            sample_valid,
  output logic [63:0]     sample_in
);
  logic [7:0] cnt_reg;
  logic       neg_reg;
  logic       tick;
  assign tick = (cnt_reg == period - 8'h01);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg      <= 8'h00; // Silent while the core is held in reset
      sample_valid <= 1'b0;
      neg_reg      <= 1'b0;
      sample_in    <= 64'h0;
    end else begin
      sample_valid <= tick; // One sample per shared period
      cnt_reg      <= tick ? 8'h00 : cnt_reg + 8'h01;
      neg_reg      <= tick ? ~neg_reg : neg_reg;
      // Alternating sign makes one sample of latency visible; lanes are garbage between samples
      sample_in    <= tick ? {4{neg_reg ? -amp : amp}} : ~sample_in;
    end
  end
endmodule : sample_source

// File: testbench/tb_top.sv
`timescale 1ns/1ps
`include "drc_regs.svh"
module tb_top;
  import drc_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic        awready, wready, bvalid, arready, rvalid, sv, ov, trig, last_sign;
  logic [1:0]  bresp, rresp, act;
  logic [63:0] sin, sout;
  int          error_cnt, checks_done;
  logic [11:0] ra [9] = '{`ENA1_OFF, `CFG1_OFF, `ENA2_OFF, `CFG2_OFF, `KNEE1_OFF, `GAIN1_OFF, `KNEE2_OFF,
                          `GAIN2_OFF, `STS_OFF};
  logic [31:0] rv [9] = '{32'h0, `CFG_RESET, 32'h0, `CFG_RESET, `KNEE_RESET, `GAIN_RESET, `KNEE_RESET,
                          `GAIN_RESET, 32'h0};
  dynamic_range_control #(.CHAN_CYCLES(8)) dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .sample_valid(sv), .sample_in(sin), .out_valid(ov), .sample_out(sout),
    .activity_detect(act), .sequencer_trigger(trig));
  // Twenty cycles per sample: room for two lanes of eight cycles, not four
  sample_source u_src (.aclk(aclk), .aresetn(aresetn), .period(8'h14), .amp(16'h1000), .sample_valid(sv),
    .sample_in(sin));
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (sv) last_sign <= sin[15];
  end
  task check(input string what, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task stop_test;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  task hung;
    error_cnt++;
    $display("wrong value wait expected done seen timeout");
    stop_test();
  endtask : hung
  task axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int i;
    @(posedge aclk);
    {awaddr, wdata} <= {a, d};
    {awvalid, wvalid, bready} <= 3'b111;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (i == 50) hung();
    bready <= 1'b0;
    check("write response", {30'h0, bresp}, {30'h0, er});
  endtask : axi_wr
  task axi_rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    int i;
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (i == 50) hung();
    rready <= 1'b0;
    check("read data", rdata, ed);
    check("read response", {30'h0, rresp}, {30'h0, er});
  endtask : axi_rd
  task wait_out(input int n);
    int i;
    int k;
    for (k = 0; k < n; k++) begin
      for (i = 0; i < 100; i++) begin
        @(posedge aclk);
        #1;
        if (ov === 1'b1) break;
      end
      if (i == 100) hung();
    end
  endtask : wait_out
  initial begin
    error_cnt = 0;
    checks_done = 0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr, wdata} = '0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    for (int j = 0; j < 9; j++) axi_rd(ra[j], rv[j], `RESP_OKAY);
    axi_rd(12'hffc, 32'h0, `RESP_SLVERR);
    axi_wr(`STS_OFF, 32'h1, `RESP_SLVERR);
    axi_wr(`KNEE1_OFF, 32'h0012_3456, `RESP_OKAY);
    axi_rd(`KNEE1_OFF, 32'h0012_3456, `RESP_OKAY);
    $display("test registers done");
    wait_out(3);
    axi_wr(`ENA1_OFF, 32'h2, `RESP_OKAY);
    wait_out(2);
    check("right lane", {16'h0, sout[31:16]}, 32'h0);
    axi_rd(`STS_OFF, 32'h1, `RESP_OKAY);
    axi_wr(`ENA1_OFF, 32'h3, `RESP_OKAY);
    axi_wr(`ENA2_OFF, 32'h3, `RESP_OKAY);
    wait_out(2);
    check("left sign", {31'h0, sout[15]}, {31'h0, last_sign});
    check("pair two lanes", sout[63:32], 32'h0);
    axi_rd(`STS_OFF, 32'h3, `RESP_OKAY);
    $display("test grant done");
    axi_wr(`CFG1_OFF, `CFG_RESET | 32'h4, `RESP_OKAY);
    wait_out(4);
    check("delayed sign", {31'h0, sout[15]}, {31'h0, ~last_sign});
    $display("test clip done");
    axi_wr(`GAIN1_OFF, `GAIN_RESET | 32'h003e_0000, `RESP_OKAY);
    axi_wr(`CFG1_OFF, `CFG_RESET | 32'h70, `RESP_OKAY);
    axi_wr(`GAIN2_OFF, `GAIN_RESET | 32'h003e_0000, `RESP_OKAY);
    axi_wr(`CFG2_OFF, `CFG_RESET | 32'h70, `RESP_OKAY);
    wait_out(60);
    check("activity", {30'h0, act}, 32'h1);
    check("trigger", {31'h0, trig}, 32'h1);
    axi_rd(`STS_OFF, 32'h13, `RESP_OKAY);
    axi_wr(`CFG1_OFF, `CFG_RESET | 32'h40, `RESP_OKAY);
    wait_out(1);
    check("activity off", {30'h0, act}, 32'h0);
    check("trigger off", {31'h0, trig}, 32'h0);
    axi_wr(`ENA1_OFF, 32'h0, `RESP_OKAY);
    wait_out(3);
    check("pair two activity", {30'h0, act}, 32'h2);
    check("pair two trigger", {31'h0, trig}, 32'h0);
    axi_rd(`STS_OFF, 32'h2c, `RESP_OKAY);
    axi_wr(`CFG2_OFF, `CFG_RESET | 32'h10, `RESP_OKAY);
    wait_out(40);
    check("peak mode steady", {30'h0, act}, 32'h0);
    $display("test detect done");
    stop_test();
  end
endmodule : tb_top
